/* include/clock_ctrl_pkg.sv */
// constants shared by the main clock selector and prescaler
// assumes an 8-bit register port with a 5-bit byte offset
package clock_ctrl_pkg;
	localparam logic [4:0] OFS_CTRL_A = 5'h00;
	localparam logic [4:0] OFS_CTRL_B = 5'h01;
	localparam logic [4:0] OFS_LOCK = 5'h02;
	localparam logic [4:0] OFS_STATUS = 5'h03;
	localparam logic [4:0] OFS_FAST_CTRL = 5'h10;
	localparam logic [4:0] OFS_FAST_CAL_A = 5'h11;
	localparam logic [4:0] OFS_FAST_CAL_B = 5'h12;
	localparam logic [4:0] OFS_ULP_CTRL = 5'h18;
	localparam logic [4:0] OFS_XTAL_CTRL = 5'h1C;

	localparam logic [7:0] CTRL_A_RESET = 8'h00;
	localparam logic [7:0] CTRL_B_RESET = 8'h11;
	localparam logic [7:0] STATUS_RESET = 8'h00;
	localparam logic [7:0] OSC_CTRL_RESET = 8'h00;

	localparam int SYSTEM_CLOCK_OUTPUT_ENABLE_BIT = 7;
	localparam int SEL_LSB = 0;
	localparam int PEN_BIT = 0;
	localparam int PRESCALER_DIVISION_FIELD_LSB = 1;
	localparam int SETTINGS_LOCK_BIT_BIT = 0;
	localparam int RUN_IN_STANDBY_BIT_BIT = 1;
	localparam int XTAL_ENABLE_BIT = 0;
	localparam int XTAL_SEL_BIT = 2;
	localparam int XTAL_CRYSTAL_STARTUP_TIME_LSB = 4;
	localparam int CAL_LOCK_BIT = 7;
	localparam int SWITCHING_BIT = 0;
	localparam int STABLE_LSB = 4;

	localparam logic [1:0] SRC_FAST = 2'h0;
	localparam logic [1:0] SRC_ULP = 2'h1;
	localparam logic [1:0] SRC_XTAL = 2'h2;
	localparam logic [1:0] SRC_EXT = 2'h3;

	localparam logic [2:0] UNLOCK_INSTR = 3'h4;
	localparam logic [16:0] FAST_START_EDGES = 17'h00004;
	localparam logic [16:0] ULP_START_EDGES = 17'h00004;
	localparam logic [16:0] EXT_START_EDGES = 17'h00002;
	localparam logic [16:0] XTAL_START_1K = 17'h00400;

	// half period of the peripheral clock in main clock periods
	function automatic logic [5:0] div_half(input logic [3:0] code);
		case (code)
			4'h0: div_half = 6'h01;
			4'h1: div_half = 6'h02;
			4'h2: div_half = 6'h04;
			4'h3: div_half = 6'h08;
			4'h4: div_half = 6'h10;
			4'h5: div_half = 6'h20;
			4'h8: div_half = 6'h03;
			4'h9: div_half = 6'h05;
			4'hA: div_half = 6'h06;
			4'hB: div_half = 6'h0C;
			4'hC: div_half = 6'h18;
			default: div_half = 6'h01;
		endcase
	endfunction
endpackage

/* hw/main_clock_select_prescaler.sv */
// main clock source selector, prescaler, clock output and protected registers
// assumes oscillator clocks arrive as pins much slower than core_clk_i; other inputs share core_clk_i
//
// Design decision made here: the address-and-strobe port.
`timescale 1ns/1ns
module main_clock_select_prescaler #(
	parameter logic [16:0] XTAL_START_16K = 17'h04000,
	parameter logic [16:0] XTAL_START_32K = 17'h08000,
	parameter logic [16:0] XTAL_START_64K = 17'h10000
) (
	input wire logic core_clk_i,
	input wire logic rst_i,
	input wire logic [4:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	output logic [7:0] reg_rdata_o,
	input wire logic unlock_key_write_i,
	input wire logic instr_retire_i,
	input wire logic [3:0] osc_clk_i,
	input wire logic [3:0] periph_request_i,
	input wire logic sleep_i,
	input wire logic sysclk_in_use_i,
	input wire logic oscillator_lock_fuse_i,
	input wire logic calib_lock_fuse_i,
	input wire logic [6:0] fast_osc_frequency_trim_fuse_i,
	input wire logic [3:0] fast_osc_temperature_trim_fuse_i,
	output logic peripheral_clock_o,
	output logic clock_out_o,
	output logic [1:0] main_source_o
);
	import clock_ctrl_pkg::*;

	logic [3:0] osc_s1, osc_s2, osc_s3, osc_rise, osc_fall;
	logic [2:0] unlock_cnt;
	logic unlocked, prot_wr, fuse_loaded;
	logic settings_lock, calib_lock;
	logic system_clock_output_enable;
	logic [1:0] main_source_select, active_sel;
	logic [3:0] prescaler_division_field;
	logic prescaler_enable_bit;
	logic [6:0] fast_osc_frequency_trim;
	logic [3:0] fast_osc_temperature_trim;
	logic fast_run_in_standby_bit, ulp_run_in_standby_bit, xtal_run_in_standby_bit, xtal_enable, xtal_sel;
	logic [1:0] crystal_startup_time;
	logic [3:0] requested, run_en, stable_raw, stable_flag;
	logic [16:0] run_cnt [4];
	logic [16:0] thr [4];
	logic switching, ext_pending, switch_ready, cfg_change;
	logic [5:0] act_half, tgt_half, half_cnt;
	logic act_pen, wait_fall, mrise, mfall;
	logic [7:0] status;

	// oscillator pins through two flops, then edge detection
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			osc_s1 <= 4'h0;
			osc_s2 <= 4'h0;
			osc_s3 <= 4'h0;
		end else begin
			osc_s1 <= osc_clk_i;
			osc_s2 <= osc_s1;
			osc_s3 <= osc_s2;
		end
	end
	assign osc_rise = osc_s2 & ~osc_s3;
	assign osc_fall = ~osc_s2 & osc_s3;

	// unlock window counted in retired instructions
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			unlock_cnt <= 3'h0;
		end else if (unlock_key_write_i) begin
			unlock_cnt <= UNLOCK_INSTR;
		end else if (instr_retire_i && unlock_cnt != 3'h0) begin
			unlock_cnt <= unlock_cnt - 3'h1;
		end
	end
	assign unlocked = unlock_cnt != 3'h0;
	assign prot_wr = reg_wr_i && unlocked;

	// fuse values are taken in the first cycle after reset release
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			fuse_loaded <= 1'b0;
		end else begin
			fuse_loaded <= 1'b1;
		end
	end

	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			settings_lock <= 1'b0;
		end else if (!fuse_loaded) begin
			settings_lock <= oscillator_lock_fuse_i;
		end else if (prot_wr && reg_addr_i == OFS_LOCK && !settings_lock) begin
			settings_lock <= reg_wdata_i[SETTINGS_LOCK_BIT_BIT];
		end
	end

	assign switching = main_source_select != active_sel;
	assign ext_pending = switching && main_source_select[1];

	// main control a: clock output and source select
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			system_clock_output_enable <= CTRL_A_RESET[SYSTEM_CLOCK_OUTPUT_ENABLE_BIT];
			main_source_select <= CTRL_A_RESET[SEL_LSB +: 2];
		end else if (prot_wr && reg_addr_i == OFS_CTRL_A && !settings_lock) begin
			system_clock_output_enable <= reg_wdata_i[SYSTEM_CLOCK_OUTPUT_ENABLE_BIT];
			if (!ext_pending) begin
				main_source_select <= reg_wdata_i[SEL_LSB +: 2];
			end
		end
	end

	// main control b: prescaler, writable at run time
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			prescaler_division_field <= CTRL_B_RESET[PRESCALER_DIVISION_FIELD_LSB +: 4];
			prescaler_enable_bit <= CTRL_B_RESET[PEN_BIT];
		end else if (prot_wr && reg_addr_i == OFS_CTRL_B && !settings_lock) begin
			prescaler_division_field <= reg_wdata_i[PRESCALER_DIVISION_FIELD_LSB +: 4];
			prescaler_enable_bit <= reg_wdata_i[PEN_BIT];
		end
	end

	// fast oscillator calibration, loaded from fuses
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			fast_osc_frequency_trim <= 7'h00;
			fast_osc_temperature_trim <= 4'h0;
			calib_lock <= 1'b0;
		end else if (!fuse_loaded) begin
			fast_osc_frequency_trim <= fast_osc_frequency_trim_fuse_i;
			fast_osc_temperature_trim <= fast_osc_temperature_trim_fuse_i;
			calib_lock <= calib_lock_fuse_i;
		end else if (prot_wr && !calib_lock && !(settings_lock && active_sel == SRC_FAST)) begin
			if (reg_addr_i == OFS_FAST_CAL_A) begin
				fast_osc_frequency_trim <= reg_wdata_i[6:0];
			end else if (reg_addr_i == OFS_FAST_CAL_B) begin
				fast_osc_temperature_trim <= reg_wdata_i[3:0];
			end
		end
	end

	// oscillator control registers
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			fast_run_in_standby_bit <= OSC_CTRL_RESET[RUN_IN_STANDBY_BIT_BIT];
			ulp_run_in_standby_bit <= OSC_CTRL_RESET[RUN_IN_STANDBY_BIT_BIT];
			xtal_run_in_standby_bit <= OSC_CTRL_RESET[RUN_IN_STANDBY_BIT_BIT];
			xtal_enable <= OSC_CTRL_RESET[XTAL_ENABLE_BIT];
			xtal_sel <= OSC_CTRL_RESET[XTAL_SEL_BIT];
			crystal_startup_time <= OSC_CTRL_RESET[XTAL_CRYSTAL_STARTUP_TIME_LSB +: 2];
		end else if (prot_wr) begin
			if (reg_addr_i == OFS_FAST_CTRL) begin
				fast_run_in_standby_bit <= reg_wdata_i[RUN_IN_STANDBY_BIT_BIT];
			end else if (reg_addr_i == OFS_ULP_CTRL) begin
				ulp_run_in_standby_bit <= reg_wdata_i[RUN_IN_STANDBY_BIT_BIT];
			end else if (reg_addr_i == OFS_XTAL_CTRL) begin
				xtal_run_in_standby_bit <= reg_wdata_i[RUN_IN_STANDBY_BIT_BIT];
				xtal_enable <= reg_wdata_i[XTAL_ENABLE_BIT];
				if (!xtal_enable && !stable_raw[SRC_XTAL]) begin
					xtal_sel <= reg_wdata_i[XTAL_SEL_BIT];
					crystal_startup_time <= reg_wdata_i[XTAL_CRYSTAL_STARTUP_TIME_LSB +: 2];
				end
			end
		end
	end

	// start-up edge counts per source
	always_comb begin
		thr[SRC_FAST] = FAST_START_EDGES;
		thr[SRC_ULP] = ULP_START_EDGES;
		thr[SRC_EXT] = EXT_START_EDGES;
		if (xtal_sel) begin
			thr[SRC_XTAL] = EXT_START_EDGES;
		end else begin
			case (crystal_startup_time)
				2'h0: thr[SRC_XTAL] = XTAL_START_1K;
				2'h1: thr[SRC_XTAL] = XTAL_START_16K;
				2'h2: thr[SRC_XTAL] = XTAL_START_32K;
				default: thr[SRC_XTAL] = XTAL_START_64K;
			endcase
		end
	end

	assign run_en = {1'b0, xtal_run_in_standby_bit & xtal_enable, ulp_run_in_standby_bit, fast_run_in_standby_bit}
		| (requested & {1'b1, xtal_enable, 2'b11});

	for (genvar k = 0; k < 4; k++) begin : g_src
		assign requested[k] = active_sel == 2'(k) || main_source_select == 2'(k) || periph_request_i[k];
		assign stable_raw[k] = run_cnt[k] >= thr[k];
		assign stable_flag[k] = stable_raw[k] && requested[k] && run_en[k];
		always_ff @(posedge core_clk_i or posedge rst_i) begin
			if (rst_i) begin
				run_cnt[k] <= 17'h00000;
			end else if (!run_en[k]) begin
				run_cnt[k] <= 17'h00000;
			end else if (osc_rise[k] && !stable_raw[k]) begin
				run_cnt[k] <= run_cnt[k] + 17'h00001;
			end
		end
	end

	// status: source flags high nibble, switch pending in bit 0
	assign status = {stable_flag[SRC_EXT], stable_flag[SRC_XTAL], stable_flag[SRC_ULP],
		stable_flag[SRC_FAST], 3'h0, switching};

	// peripheral clock generation; changes land only where a rise was due
	assign tgt_half = div_half(prescaler_division_field);
	assign switch_ready = switching && stable_raw[main_source_select];
	assign cfg_change = switch_ready || tgt_half != act_half || prescaler_enable_bit != act_pen;
	assign mrise = osc_rise[active_sel];
	assign mfall = osc_fall[active_sel];

	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			active_sel <= SRC_FAST;
			act_half <= div_half(CTRL_B_RESET[PRESCALER_DIVISION_FIELD_LSB +: 4]);
			act_pen <= CTRL_B_RESET[PEN_BIT];
			half_cnt <= 6'h00;
			wait_fall <= 1'b1;
			peripheral_clock_o <= 1'b0;
		end else if (wait_fall) begin
			half_cnt <= 6'h00;
			if (mfall) begin
				wait_fall <= 1'b0;
			end
		end else if (act_pen) begin
			if (mrise) begin
				if (half_cnt == act_half - 6'h01) begin
					half_cnt <= 6'h00;
					if (!peripheral_clock_o && cfg_change) begin
						active_sel <= switch_ready ? main_source_select : active_sel;
						act_half <= tgt_half;
						act_pen <= prescaler_enable_bit;
						wait_fall <= 1'b1;
					end else begin
						peripheral_clock_o <= ~peripheral_clock_o;
					end
				end else begin
					half_cnt <= half_cnt + 6'h01;
				end
			end
		end else if (mrise) begin
			if (cfg_change) begin
				active_sel <= switch_ready ? main_source_select : active_sel;
				act_half <= tgt_half;
				act_pen <= prescaler_enable_bit;
				wait_fall <= 1'b1;
			end else begin
				peripheral_clock_o <= 1'b1;
			end
		end else if (mfall) begin
			peripheral_clock_o <= 1'b0;
		end
	end
	assign main_source_o = active_sel;

	// system clock onto the output pin
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			clock_out_o <= 1'b0;
		end else begin
			clock_out_o <= system_clock_output_enable && (!sleep_i || sysclk_in_use_i)
				&& osc_s2[active_sel];
		end
	end

	// register read port, data in the following cycle only
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			reg_rdata_o <= 8'h00;
		end else if (!reg_rd_i) begin
			reg_rdata_o <= 8'h00;
		end else if (reg_addr_i == OFS_CTRL_A) begin
			reg_rdata_o <= {system_clock_output_enable, 5'h00, main_source_select};
		end else if (reg_addr_i == OFS_CTRL_B) begin
			reg_rdata_o <= {3'h0, prescaler_division_field, prescaler_enable_bit};
		end else if (reg_addr_i == OFS_LOCK) begin
			reg_rdata_o <= {7'h00, settings_lock};
		end else if (reg_addr_i == OFS_STATUS) begin
			reg_rdata_o <= status;
		end else if (reg_addr_i == OFS_FAST_CTRL) begin
			reg_rdata_o <= {6'h00, fast_run_in_standby_bit, 1'b0};
		end else if (reg_addr_i == OFS_FAST_CAL_A) begin
			reg_rdata_o <= {1'b0, fast_osc_frequency_trim};
		end else if (reg_addr_i == OFS_FAST_CAL_B) begin
			reg_rdata_o <= {calib_lock, 3'h0, fast_osc_temperature_trim};
		end else if (reg_addr_i == OFS_ULP_CTRL) begin
			reg_rdata_o <= {6'h00, ulp_run_in_standby_bit, 1'b0};
		end else if (reg_addr_i == OFS_XTAL_CTRL) begin
			reg_rdata_o <= {2'h0, crystal_startup_time, 1'b0, xtal_sel, xtal_run_in_standby_bit, xtal_enable};
		end else begin
			reg_rdata_o <= 8'h00;
		end
	end

	property p_window_closes;
		@(posedge core_clk_i) disable iff (rst_i)
		unlock_key_write_i ##1 (!unlock_key_write_i && instr_retire_i) [*4] |=> !unlocked;
	endproperty
	a_window_closes: assert property (p_window_closes) else $error("unlock window outlived four instructions");

	property p_unprotected_ignored;
		@(posedge core_clk_i) disable iff (rst_i)
		reg_wr_i && !unlocked && reg_addr_i == OFS_CTRL_B
		|=> {prescaler_division_field, prescaler_enable_bit} == $past({prescaler_division_field, prescaler_enable_bit});
	endproperty
	a_unprotected_ignored: assert property (p_unprotected_ignored) else $error("unprotected write changed control b");

	property p_system_clock_output_enable_gate;
		@(posedge core_clk_i) disable iff (rst_i)
		clock_out_o |-> $past(system_clock_output_enable && (!sleep_i || sysclk_in_use_i));
	endproperty
	a_system_clock_output_enable_gate: assert property (p_system_clock_output_enable_gate) else $error("clock output while disabled or asleep");

	property p_undivided_follows;
		@(posedge core_clk_i) disable iff (rst_i)
		!act_pen && !wait_fall && mrise && !cfg_change |=> peripheral_clock_o ##1 peripheral_clock_o;
	endproperty
	a_undivided_follows: assert property (p_undivided_follows) else $error("undivided clock did not rise");

	property p_lock_freezes;
		@(posedge core_clk_i) disable iff (rst_i)
		fuse_loaded && settings_lock && reg_wr_i && reg_addr_i == OFS_CTRL_A
		|=> main_source_select == $past(main_source_select) && settings_lock;
	endproperty
	a_lock_freezes: assert property (p_lock_freezes) else $error("locked control a changed");

	property p_fuse_load;
		@(posedge core_clk_i) disable iff (rst_i)
		!fuse_loaded |=> settings_lock == $past(oscillator_lock_fuse_i);
	endproperty
	a_fuse_load: assert property (p_fuse_load) else $error("lock bit not taken from fuse");

	property p_status_unrequested;
		@(posedge core_clk_i) disable iff (rst_i)
		reg_rd_i && reg_addr_i == OFS_STATUS && !requested[SRC_XTAL] |=> !reg_rdata_o[STABLE_LSB + 2];
	endproperty
	a_status_unrequested: assert property (p_status_unrequested) else $error("unrequested crystal read stable");

	property p_switch_waits;
		@(posedge core_clk_i) disable iff (rst_i)
		switching && !stable_raw[main_source_select] |=> active_sel == $past(active_sel);
	endproperty
	a_switch_waits: assert property (p_switch_waits) else $error("switch before new source stable");

	property p_after_reset;
		@(posedge core_clk_i) disable iff (rst_i)
		!fuse_loaded |-> active_sel == SRC_FAST && act_half == 6'h03 && act_pen;
	endproperty
	a_after_reset: assert property (p_after_reset) else $error("reset clock setting wrong");

	property p_ext_blocks;
		@(posedge core_clk_i) disable iff (rst_i)
		ext_pending && reg_wr_i && reg_addr_i == OFS_CTRL_A |=> main_source_select == $past(main_source_select);
	endproperty
	a_ext_blocks: assert property (p_ext_blocks) else $error("source changed during external switch");

	property p_cal_locked;
		@(posedge core_clk_i) disable iff (rst_i)
		fuse_loaded && settings_lock && active_sel == SRC_FAST && reg_wr_i && reg_addr_i == OFS_FAST_CAL_A
		|=> fast_osc_frequency_trim == $past(fast_osc_frequency_trim);
	endproperty
	a_cal_locked: assert property (p_cal_locked) else $error("locked calibration changed");
endmodule

/* tb/tb.sv */
// self-checking bench for the main clock selector and prescaler
// assumes the design package is compiled first; oscillators are made here from core_clk_i
`timescale 1ns/1ns
module tb;
	import clock_ctrl_pkg::*;
	logic core_clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic [4:0] reg_addr_i = 5'h00;
	logic [7:0] reg_wdata_i = 8'h00;
	logic reg_wr_i = 1'b0;
	logic reg_rd_i = 1'b0;
	logic [7:0] reg_rdata_o;
	logic unlock_key_write_i = 1'b0;
	logic instr_retire_i = 1'b0;
	logic [3:0] osc_clk_i = 4'h0;
	logic [3:0] periph_request_i = 4'h0;
	logic sleep_i = 1'b0;
	logic sysclk_in_use_i = 1'b0;
	logic oscillator_lock_fuse_i = 1'b0;
	logic calib_lock_fuse_i = 1'b0;
	logic peripheral_clock_o;
	logic clock_out_o;
	logic [1:0] main_source_o;
	logic [3:0] run_osc = 4'h1;
	logic [2:0] osc_cnt = 3'h0;
	logic pclk_q = 1'b0;
	logic [15:0] n;
	logic [7:0] d;
	int mismatches = 0;
	int check_count = 0;
	// protected registers: offset, value before, value written
	logic [4:0] p_addr [6] = '{OFS_CTRL_B, OFS_FAST_CTRL, OFS_ULP_CTRL, OFS_XTAL_CTRL, OFS_FAST_CAL_A, OFS_FAST_CAL_B};
	logic [7:0] p_old [6] = '{8'h11, 8'h00, 8'h00, 8'h00, 8'h55, 8'h09};
	logic [7:0] p_new [6] = '{8'h17, 8'h02, 8'h02, 8'h34, 8'h2A, 8'h03};
	// prescaler codes and their divisors
	logic [3:0] codes [11] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h8, 4'h9, 4'hA, 4'hB, 4'hC};
	logic [7:0] divs [11] = '{8'h02, 8'h04, 8'h08, 8'h10, 8'h20, 8'h40, 8'h06, 8'h0A, 8'h0C, 8'h18, 8'h30};

	main_clock_select_prescaler #(.XTAL_START_16K(17'h00010), .XTAL_START_32K(17'h00020),
		.XTAL_START_64K(17'h00040)) DUT (
		.core_clk_i(core_clk_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
		.reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
		.unlock_key_write_i(unlock_key_write_i), .instr_retire_i(instr_retire_i), .osc_clk_i(osc_clk_i),
		.periph_request_i(periph_request_i), .sleep_i(sleep_i), .sysclk_in_use_i(sysclk_in_use_i),
		.oscillator_lock_fuse_i(oscillator_lock_fuse_i), .calib_lock_fuse_i(calib_lock_fuse_i),
		.fast_osc_frequency_trim_fuse_i(7'h55), .fast_osc_temperature_trim_fuse_i(4'h9),
		.peripheral_clock_o(peripheral_clock_o), .clock_out_o(clock_out_o), .main_source_o(main_source_o));

	always #2 core_clk_i = ~core_clk_i;

	// oscillators: period of 8 core cycles, stopped ones stand low
	always @(posedge core_clk_i) begin
		osc_cnt <= osc_cnt + 3'h1;
		osc_clk_i <= run_osc & {4{osc_cnt[2]}};
		pclk_q <= peripheral_clock_o;
	end

	task conclude;
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	task check(input logic [15:0] seen, input logic [15:0] exp);
		check_count++;
		if (seen !== exp) begin
			mismatches++;
			$display("Error at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	task hang;
		mismatches++;
		$display("Error at %0t: wait ran out", $time);
		conclude;
	endtask

	task do_reset;
		rst_i <= 1'b1;
		repeat (12) @(posedge core_clk_i);
		rst_i <= 1'b0;
		repeat (2) @(posedge core_clk_i);
	endtask

	task wr(input logic [4:0] a, input logic [7:0] v);
		@(posedge core_clk_i);
		reg_addr_i <= a;
		reg_wdata_i <= v;
		reg_wr_i <= 1'b1;
		@(posedge core_clk_i);
		reg_wr_i <= 1'b0;
	endtask

	task rd(input logic [4:0] a, output logic [7:0] v);
		@(posedge core_clk_i);
		reg_addr_i <= a;
		reg_rd_i <= 1'b1;
		@(posedge core_clk_i);
		reg_rd_i <= 1'b0;
		#1 v = reg_rdata_o;
	endtask

	task rchk(input logic [4:0] a, input logic [7:0] exp);
		rd(a, d);
		check({8'h00, d}, {8'h00, exp});
	endtask

	task key;
		@(posedge core_clk_i);
		unlock_key_write_i <= 1'b1;
		@(posedge core_clk_i);
		unlock_key_write_i <= 1'b0;
	endtask

	task retire(input int k);
		repeat (k) begin
			@(posedge core_clk_i);
			instr_retire_i <= 1'b1;
			@(posedge core_clk_i);
			instr_retire_i <= 1'b0;
		end
	endtask

	// unlocked write, then the window is closed again
	task pwr(input logic [4:0] a, input logic [7:0] v);
		key;
		wr(a, v);
		retire(4);
	endtask

	// core cycles up to the next rising edge of the peripheral clock
	task rise(output logic [15:0] c);
		c = 16'h0000;
		do begin
			@(posedge core_clk_i);
			c++;
		end while (!(peripheral_clock_o === 1'b1 && pclk_q === 1'b0) && c < 16'h07D0);
		if (c >= 16'h07D0) hang;
	endtask

	task meas(output logic [15:0] c);
		rise(c);
		rise(c);
		rise(c);
	endtask

	// 1 when the clock output pin changed within 64 cycles
	task togg(output logic [15:0] c);
		logic prev;
		// let a just changed enable or sleep level reach the registered pin first
		repeat (2) @(posedge core_clk_i);
		c = 16'h0000;
		prev = clock_out_o;
		repeat (64) begin
			@(posedge core_clk_i);
			if (clock_out_o !== prev) c = 16'h0001;
			prev = clock_out_o;
		end
	endtask

	task wait_src(input logic [1:0] s);
		int i;
		for (i = 0; i < 1000 && main_source_o !== s; i++) @(posedge core_clk_i);
		if (main_source_o !== s) hang;
	endtask

	initial begin
		do_reset;
		rchk(OFS_STATUS, 8'h00);
		@(posedge core_clk_i);
		#1 check({8'h00, reg_rdata_o}, 16'h0000);
		rchk(OFS_CTRL_A, 8'h00);
		rchk(OFS_CTRL_B, 8'h11);
		rchk(OFS_LOCK, 8'h00);
		rchk(5'h05, 8'h00);
		$display("reset values done");
		for (int k = 0; k < 6; k++) begin
			wr(p_addr[k], p_new[k]);
			rchk(p_addr[k], p_old[k]);
			pwr(p_addr[k], p_new[k]);
			rchk(p_addr[k], p_new[k]);
		end
		key;
		retire(3);
		wr(OFS_CTRL_B, 8'h03);
		rchk(OFS_CTRL_B, 8'h03);
		retire(1);
		wr(OFS_CTRL_B, 8'h05);
		rchk(OFS_CTRL_B, 8'h03);
		// four retires back to back right after the key close the window
		key;
		instr_retire_i <= 1'b1;
		repeat (4) @(posedge core_clk_i);
		instr_retire_i <= 1'b0;
		wr(OFS_CTRL_B, 8'h05);
		rchk(OFS_CTRL_B, 8'h03);
		$display("protection done");
		for (int k = 0; k < 11; k++) begin
			pwr(OFS_CTRL_B, {3'h0, codes[k], 1'b1});
			meas(n);
			check(n, {5'h00, divs[k], 3'h0});
		end
		pwr(OFS_CTRL_B, 8'h18);
		meas(n);
		check(n, 16'h0008);
		pwr(OFS_CTRL_B, 8'h01);
		$display("prescaler done");
		togg(n);
		check(n, 16'h0000);
		pwr(OFS_CTRL_A, 8'h80);
		togg(n);
		check(n, 16'h0001);
		sleep_i <= 1'b1;
		togg(n);
		check(n, 16'h0000);
		sysclk_in_use_i <= 1'b1;
		togg(n);
		check(n, 16'h0001);
		sleep_i <= 1'b0;
		sysclk_in_use_i <= 1'b0;
		$display("clock output done");
		pwr(OFS_CTRL_A, 8'h81);
		rchk(OFS_STATUS, 8'h11);
		run_osc <= 4'h3;
		wait_src(SRC_ULP);
		check({14'h0000, main_source_o}, {14'h0000, SRC_ULP});
		rchk(OFS_STATUS, 8'h20);
		@(posedge core_clk_i);
		periph_request_i <= 4'h1;
		rchk(OFS_STATUS, 8'h30);
		@(posedge core_clk_i);
		periph_request_i <= 4'h0;
		pwr(OFS_CTRL_A, 8'h83);
		rchk(OFS_STATUS, 8'h21);
		pwr(OFS_CTRL_A, 8'h81);
		rchk(OFS_CTRL_A, 8'h83);
		check({14'h0000, main_source_o}, {14'h0000, SRC_ULP});
		run_osc <= 4'hB;
		wait_src(SRC_EXT);
		check({14'h0000, main_source_o}, {14'h0000, SRC_EXT});
		rchk(OFS_STATUS, 8'h80);
		$display("source switch done");
		pwr(OFS_LOCK, 8'h01);
		rchk(OFS_LOCK, 8'h01);
		pwr(OFS_CTRL_A, 8'h80);
		rchk(OFS_CTRL_A, 8'h83);
		pwr(OFS_CTRL_B, 8'h03);
		rchk(OFS_CTRL_B, 8'h01);
		$display("software lock done");
		@(posedge core_clk_i);
		oscillator_lock_fuse_i <= 1'b1;
		do_reset;
		check({14'h0000, main_source_o}, {14'h0000, SRC_FAST});
		rchk(OFS_LOCK, 8'h01);
		pwr(OFS_CTRL_B, 8'h03);
		rchk(OFS_CTRL_B, 8'h11);
		pwr(OFS_FAST_CAL_A, 8'h2A);
		rchk(OFS_FAST_CAL_A, 8'h55);
		meas(n);
		check(n, 16'h0030);
		$display("fuse lock done");
		@(posedge core_clk_i);
		oscillator_lock_fuse_i <= 1'b0;
		calib_lock_fuse_i <= 1'b1;
		do_reset;
		rchk(OFS_LOCK, 8'h00);
		rchk(OFS_FAST_CAL_B, 8'h89);
		pwr(OFS_FAST_CAL_A, 8'h2A);
		rchk(OFS_FAST_CAL_A, 8'h55);
		pwr(OFS_CTRL_B, 8'h03);
		rchk(OFS_CTRL_B, 8'h03);
		$display("calibration fuse done");
		conclude;
	end
endmodule
